// ---- core/ffmd_detector.sv ----
// Freefall and motion detector with debounce and source register
`timescale 1ns/100ps

// Overview of operation
// - Event-active set when selected combination true
// - Motion axis true when magnitude exceeds threshold
// - Freefall true when all enabled axes at/below threshold and at least one axis is enabled
// - Interrupt from event-active, enable and route
// - Source: active bit7, bit6 zero, axis pairs
// - Disabled axis flag and polarity read zero
// - Polarity zero positive, one negative
// - Threshold unsigned seven bits, resets zero
// - Threshold step one sixteenth g
// - Threshold covers eight g at any range
// - Threshold bit7 selects debounce mode
// - Mode one clears counter when false
// - Mode zero decrements counter toward zero
// - Debounce count full eight bits, resets zero
// - Counter increments per matching sample
// - Event when counter equals programmed count
// - Counter saturates at programmed count
// - Debounce step is one output sample
// - Combine select: zero AND, one OR
// - Latch freezes flags; source read clears
// - Unlatched flags follow live status
module ffmd_detector import ffmd_pkg::*; #(
  parameter int SAMPLE_W = 12
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Output samples, one strobe per data-rate period
  input wire logic sample_valid,
  input wire logic signed [SAMPLE_W-1:0] accel_x,
  input wire logic signed [SAMPLE_W-1:0] accel_y,
  input wire logic signed [SAMPLE_W-1:0] accel_z,
  input wire logic [1:0] full_scale,
  // Register port
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  // Interrupt configuration and pins
  input wire logic detect_irq_enable,
  input wire logic detect_irq_route,
  output logic irq_pin1_q,
  output logic irq_pin2_q
);

  // Magnitude compare needs room for a 7-bit count shifted by six
  localparam int CMP_W = SAMPLE_W + 2;

  // Narrower samples cannot represent the eight g span
  if (SAMPLE_W < 11) begin : g_width_check
    $error("SAMPLE_W must be at least 11");
  end

  // Registers
  logic [7:0] detect_config_q; // Latch, combine, axis enables
  logic [7:0] detect_threshold_q; // Mode bit and threshold value
  logic [7:0] debounce_count_q; // Programmed debounce length
  logic [7:0] cnt_q; // Internal debounce counter
  logic [7:0] cnt_d;
  logic live_q; // Debounced condition at last sample
  logic live_d;
  logic event_active_q; // Reported event-active bit
  logic [NUM_AXES-1:0] flag_q; // Axis event flags, x at bit 0
  logic [NUM_AXES-1:0] pol_q; // Axis polarity bits

  // Decoded controls
  logic latch_enable;
  logic combine_select;
  logic debounce_mode;
  logic [THS_VALUE_W-1:0] threshold_value;
  logic [NUM_AXES-1:0] axis_enable; // {z, y, x}
  assign latch_enable = detect_config_q[CFG_LATCH_BIT];
  assign combine_select = detect_config_q[CFG_COMBINE_BIT];
  assign axis_enable = detect_config_q[CFG_ENABLE_LSB +: NUM_AXES];
  assign debounce_mode = detect_threshold_q[THS_MODE_BIT];
  assign threshold_value = detect_threshold_q[THS_VALUE_W-1:0];

  // Register access strobes
  logic src_read; // Host reads the source register
  logic read_clear; // Read that empties a latched source
  assign src_read = reg_rd && (reg_addr == ADDR_SOURCE);
  assign read_clear = src_read && latch_enable;

  // Threshold in sample counts for the selected range
  logic [2:0] ths_shift;
  logic [CMP_W-1:0] ths_scaled;
  always_comb begin
    unique case (full_scale)
      FS_2G: ths_shift = SHIFT_2G;
      FS_4G: ths_shift = SHIFT_4G;
      default: ths_shift = SHIFT_8G;
    endcase
  end
  // scaled span
  // Shifting rather than clipping keeps eight g reachable in every range
  assign ths_scaled = CMP_W'(threshold_value) << ths_shift;

  // Per-axis compare
  logic signed [SAMPLE_W-1:0] axis_s [NUM_AXES];
  logic [NUM_AXES-1:0] axis_high; // Above threshold, enabled
  logic [NUM_AXES-1:0] axis_low; // At or below threshold
  logic [NUM_AXES-1:0] axis_neg; // Negative acceleration
  assign axis_s[0] = accel_x;
  assign axis_s[1] = accel_y;
  assign axis_s[2] = accel_z;

  for (genvar i = 0; i < NUM_AXES; i++) begin : g_axis
    logic [SAMPLE_W-1:0] mag;
    // Two's complement magnitude; the most negative code still fits
    assign mag = axis_s[i][SAMPLE_W-1] ? SAMPLE_W'(-axis_s[i])
                                       : SAMPLE_W'(axis_s[i]);
    assign axis_high[i] = axis_enable[i] &&
                          ({2'h0, mag} > ths_scaled);
    assign axis_low[i] = ({2'h0, mag} <= ths_scaled);
    assign axis_neg[i] = axis_s[i][SAMPLE_W-1];
  end

  // Combined inertial condition
  logic cond_freefall;
  logic cond_motion;
  logic cond;
  assign cond_freefall = (axis_enable != 3'h0) &&
                         (&(axis_low | ~axis_enable));
  assign cond_motion = |axis_high;
  assign cond = combine_select ? cond_motion : cond_freefall;

  // Debounce counter next value
  always_comb begin
    // A latched read restarts the count so a new event needs a full delay
    cnt_d = read_clear ? 8'h00 : cnt_q;
    if (sample_valid) begin
      if (cond) begin
        if (cnt_d >= debounce_count_q) begin
          cnt_d = debounce_count_q;
        end else begin
          cnt_d = cnt_d + 8'h01;
        end
      end else if (debounce_mode) begin
        cnt_d = 8'h00;
      end else if (cnt_d != 8'h00) begin
        cnt_d = cnt_d - 8'h01;
      end
    end
  end

  // Debounced condition, evaluated only on samples
  always_comb begin
    live_d = live_q;
    if (sample_valid) begin
      // count reached
      // A zero count qualifies on the matching sample itself
      live_d = (debounce_count_q == 8'h00) ? cond
                                           : (cnt_d == debounce_count_q);
    end
  end

  // Counter and live condition
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q <= 8'h00;
      live_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      live_q <= live_d;
    end
  end

  // Event-active bit
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      event_active_q <= 1'b0;
    end else if (!latch_enable) begin
      event_active_q <= live_d;
    end else if (sample_valid && live_d) begin
      // set, winning over a read in the same cycle
      event_active_q <= 1'b1;
    end else if (read_clear) begin
      event_active_q <= 1'b0;
    end
  end

  // Axis flags and polarity
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      flag_q <= 3'h0;
      pol_q <= 3'h0;
    end else if (sample_valid &&
                 (!latch_enable || !event_active_q || read_clear)) begin
      flag_q <= axis_high;
      pol_q <= axis_high & axis_neg;
    end else if (read_clear) begin
      flag_q <= 3'h0;
      pol_q <= 3'h0;
    end
    // Latched and active: held until the host reads
  end

  // Source register image
  logic [7:0] source_image;
  logic [NUM_AXES-1:0] flag_vis;
  logic [NUM_AXES-1:0] pol_vis;
  assign flag_vis = flag_q & axis_enable;
  assign pol_vis = pol_q & axis_enable;
  assign source_image = {event_active_q, 1'b0,
                         flag_vis[2], pol_vis[2],
                         flag_vis[1], pol_vis[1],
                         flag_vis[0], pol_vis[0]};

  // Writable registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      detect_config_q <= RST_CONFIG;
      detect_threshold_q <= RST_THRESHOLD;
      debounce_count_q <= RST_DEBOUNCE;
    end else if (reg_wr) begin
      unique case (reg_addr)
        ADDR_CONFIG: detect_config_q <= reg_wdata;
        ADDR_THRESHOLD: detect_threshold_q <= reg_wdata;
        ADDR_DEBOUNCE: debounce_count_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data, one cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_CONFIG: reg_rdata_q <= detect_config_q;
        ADDR_SOURCE: reg_rdata_q <= source_image;
        ADDR_THRESHOLD: reg_rdata_q <= detect_threshold_q;
        ADDR_DEBOUNCE: reg_rdata_q <= debounce_count_q;
        // Unmapped addresses read zero
        default: reg_rdata_q <= 8'h00;
      endcase
    end
  end

  // Interrupt pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_pin1_q <= 1'b0;
      irq_pin2_q <= 1'b0;
    end else begin
      irq_pin1_q <= event_active_q && detect_irq_enable &&
                    detect_irq_route;
      irq_pin2_q <= event_active_q && detect_irq_enable &&
                    !detect_irq_route;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Motion sample with zero count, unlatched
  sequence motion_hit_s;
    sample_valid && combine_select && !latch_enable &&
    debounce_count_q == 8'h00 && (axis_high != 3'h0);
  endsequence
  // Freefall sample with one axis above threshold
  sequence freefall_miss_s;
    sample_valid && !combine_select && !latch_enable &&
    axis_enable == 3'h7 && (axis_low != 3'h7);
  endsequence

  motion_event_a: assert property (
    motion_hit_s |=> event_active_q ##1
      (event_active_q || $past(sample_valid || reg_rd || reg_wr)))
    else $error("motion sample did not raise event-active");
  freefall_gate_a: assert property (
    freefall_miss_s |=> !event_active_q)
    else $error("freefall raised with an axis above threshold");
  source_ro_a: assert property (
    reg_wr && reg_addr == ADDR_SOURCE && !sample_valid && !reg_rd
    |=> $stable(event_active_q) && $stable(flag_q) && $stable(cnt_q))
    else $error("source write altered detector state");
  clear_mode_a: assert property (
    sample_valid && !cond && debounce_mode |=> cnt_q == 8'h00)
    else $error("clear mode left counter nonzero");
  dec_mode_a: assert property (
    sample_valid && !cond && !debounce_mode && !read_clear &&
    cnt_q != 8'h00 |=> cnt_q == 8'($past(cnt_q) - 8'h01))
    else $error("decrement mode did not step down by one");
  count_sat_a: assert property (
    sample_valid && cond && !read_clear && !reg_wr
    |=> cnt_q <= debounce_count_q)
    else $error("debounce counter passed programmed count");
  latch_hold_a: assert property (
    latch_enable && event_active_q && !src_read && !reg_wr
    |=> event_active_q && $stable(flag_q) [*1])
    else $error("latched event changed without a read");
  read_clear_a: assert property (
    read_clear && !sample_valid && !reg_wr
    |=> !event_active_q && flag_q == 3'h0 && cnt_q == 8'h00)
    else $error("latched read did not clear source");
  irq_route_a: assert property (
    event_active_q && detect_irq_enable
    |=> ($past(detect_irq_route) ? irq_pin1_q : irq_pin2_q) &&
        !(irq_pin1_q && irq_pin2_q))
    else $error("interrupt not routed from event-active");
  axis_mask_a: assert property (
    reg_rd && reg_addr == ADDR_SOURCE && !reg_wr && !axis_enable[0]
    |=> reg_rdata_q[1:0] == 2'h0)
    else $error("disabled axis bits read nonzero");

endmodule : ffmd_detector

// ---- core/ffmd_pkg.sv ----
// Register map, field positions and scaling constants of the detector
package ffmd_pkg;
  // Register offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h15;
  localparam logic [7:0] ADDR_SOURCE = 8'h16;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h17;
  localparam logic [7:0] ADDR_DEBOUNCE = 8'h18;
  // Reset values
  localparam logic [7:0] RST_CONFIG = 8'h00;
  localparam logic [7:0] RST_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_DEBOUNCE = 8'h00;
  // Configuration fields
  localparam int CFG_LATCH_BIT = 7;
  localparam int CFG_COMBINE_BIT = 6;
  localparam int CFG_ENABLE_LSB = 3;
  // Threshold fields
  localparam int THS_MODE_BIT = 7;
  localparam int THS_VALUE_W = 7;
  // Source fields
  localparam int SRC_ACTIVE_BIT = 7;
  // Full-scale range codes
  localparam logic [1:0] FS_2G = 2'h0;
  localparam logic [1:0] FS_4G = 2'h1;
  // Shift that turns a threshold count into sample counts per range
  localparam logic [2:0] SHIFT_2G = 3'h6;
  localparam logic [2:0] SHIFT_4G = 3'h5;
  localparam logic [2:0] SHIFT_8G = 3'h4;
  // Axis count
  localparam int NUM_AXES = 3;
endpackage : ffmd_pkg

// ---- verif/ffmd_host.sv ----
// Host model that reaches the detector registers over the register port
`timescale 1ns/100ps
module ffmd_host (
  // Clock
  input wire logic clk_sys,
  // Register port towards the detector
  output logic reg_rd,
  output logic reg_wr,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q
);
  // Idle bus from time zero
  initial begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // One-cycle write; called just after a falling edge
  // An idle edge follows so back-to-back calls never retoggle the strobe
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    @(negedge clk_sys);
  endtask : wr

  // One-cycle read; data is registered, so it is settled a cycle later
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    d = reg_rdata_q;
    @(negedge clk_sys);
  endtask : rd
endmodule : ffmd_host

// ---- verif/freefall_motion_detector_tb.sv ----
// Bench comparing the detector with an integer model on random samples
`timescale 1ns/100ps
module freefall_motion_detector_tb import ffmd_pkg::*;;
  // Stimulus and observed nets
  logic clk_sys, rst, sample_valid, irq_en, irq_route, pin1, pin2;
  logic signed [11:0] ax, ay, az;
  logic [1:0] fs;
  logic rd, wr;
  logic [7:0] addr, wdata, rdata, d;
  // Model state: config, threshold, count limit, counter, flags
  int cfg, ths, dbc, cnt, fl, ea, error_cnt, checks_done;
  logic [7:0] addrs [5] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h20};

  ffmd_detector u_dut (.clk_sys(clk_sys), .rst(rst),
    .sample_valid(sample_valid), .accel_x(ax), .accel_y(ay),
    .accel_z(az), .full_scale(fs), .reg_rd(rd), .reg_wr(wr),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_q(rdata),
    .detect_irq_enable(irq_en), .detect_irq_route(irq_route),
    .irq_pin1_q(pin1), .irq_pin2_q(pin2));
  ffmd_host u_host (.clk_sys(clk_sys), .reg_rd(rd), .reg_wr(wr),
    .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_q(rdata));

  // 250 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  // One random sample, model update, then irq and source compare
  task automatic do_sample();
    logic signed [11:0] v [3];
    int a, lim, nfl, any, low, cond, live;
    for (int i = 0; i < 3; i++) v[i] = 12'($urandom);
    fs = 2'($urandom);
    // Threshold spans 8 g whatever the range, so shift follows range
    lim = (ths % 128) << (fs == 0 ? 6 : fs == 1 ? 5 : 4);
    nfl = 0;
    any = 0;
    low = (cfg & 8'h38) != 0;
    for (int i = 0; i < 3; i++) begin
      a = v[i] < 0 ? -int'(v[i]) : int'(v[i]);
      if (cfg[3+i] && a > lim) begin
        nfl |= (2 | int'(v[i] < 0)) << (2 * i);
        any = 1;
        low = 0;
      end
    end
    cond = cfg[6] ? any : low;
    // Saturate at the limit; out-of-match clears or steps down
    if (cond) cnt = cnt + 1 > dbc ? dbc : cnt + 1;
    else if (ths[7]) cnt = 0;
    else if (cnt > 0) cnt--;
    live = dbc == 0 ? cond : int'(cnt == dbc);
    if (cfg[7] && ea == 0) fl = nfl;
    if (!cfg[7]) fl = nfl;
    ea = cfg[7] ? (ea | live) : live;
    ax = v[0];
    ay = v[1];
    az = v[2];
    sample_valid = 1'b1;
    @(negedge clk_sys);
    sample_valid = 1'b0;
    @(negedge clk_sys);
    // pins follow event, enable and route
    chk("irq_pin1", 8'(ea & irq_en & irq_route), {7'h00, pin1});
    chk("irq_pin2", 8'(ea & irq_en & !irq_route), {7'h00, pin2});
    u_host.rd(ADDR_SOURCE, d);
    chk("source", 8'((ea << 7) | fl), d);
    if (cfg[7]) begin
      ea = 0;
      fl = 0;
      cnt = 0;
    end
  endtask : do_sample

  // Watchdog against a hang
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    {sample_valid, irq_en, irq_route, ax, ay, az, fs} = '0;
    {cfg, ths, dbc, cnt, fl, ea, error_cnt, checks_done} = '0;
    void'($urandom(65));
    rst = 1'b1;
    repeat (3) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    // Reset values, unmapped place reads zero
    foreach (addrs[i]) begin
      u_host.rd(addrs[i], d);
      chk("reset value", 8'h00, d);
    end
    $display("test reset done");
    ths = $urandom % 256;
    dbc = $urandom % 256;
    u_host.wr(ADDR_THRESHOLD, 8'(ths));
    u_host.wr(ADDR_DEBOUNCE, 8'(dbc));
    u_host.wr(ADDR_SOURCE, 8'hff);
    u_host.rd(ADDR_THRESHOLD, d);
    chk("threshold", 8'(ths), d);
    u_host.rd(ADDR_DEBOUNCE, d);
    chk("debounce", 8'(dbc), d);
    u_host.rd(ADDR_SOURCE, d);
    chk("source write", 8'h00, d);
    $display("test registers done");
    // Random blocks of samples, each under a new setup
    for (int n = 0; n < 120; n++) begin
      if (n % 8 == 0) begin
        cfg = $urandom & 8'hf8;
        ths = $urandom % 256;
        dbc = $urandom % 4;
        cnt = 0;
        irq_en = 1'($urandom);
        irq_route = 1'($urandom);
        u_host.wr(ADDR_CONFIG, 8'(cfg | 8'h80));
        u_host.wr(ADDR_THRESHOLD, 8'(ths));
        u_host.wr(ADDR_DEBOUNCE, 8'(dbc));
        u_host.rd(ADDR_SOURCE, d);
        ea = 0;
        fl = 0;
        u_host.wr(ADDR_CONFIG, 8'(cfg));
      end
      do_sample();
    end
    $display("test random samples done");
    tally_and_finish();
  end
endmodule : freefall_motion_detector_tb
